// ---- design/cca_defines.vh ----
/*
  Constants for the counter array block: register byte offsets on the
  APB bus, bit positions inside each register, writable masks, reset
  values and prescaler divide ratios.
  Assumes it is included by bare name from design files only.
*/
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH

// Register byte offsets
`define CCA_OFF_CTRL      12'h000
`define CCA_OFF_MODE      12'h004
`define CCA_OFF_TLOW      12'h008
`define CCA_OFF_THIGH     12'h00c
`define CCA_PAGE_MODMODE  7'h01
`define CCA_PAGE_MODLO    7'h02
`define CCA_PAGE_MODHI    7'h03
`define CCA_NUM_MOD       3'h5
`define CCA_GUARD_MOD     4

// counter_ctrl_reg fields
`define CCA_CTRL_OVF      7
`define CCA_CTRL_RUN      6
`define CCA_CTRL_MASK     8'hdf
`define CCA_CTRL_RESET    8'h00

// counter_mode_reg fields
`define CCA_MODE_IDLE     7
`define CCA_MODE_GUARD    6
`define CCA_MODE_SEL_HI   2
`define CCA_MODE_SEL_LO   1
`define CCA_MODE_OVF_IE   0
`define CCA_MODE_MASK     8'hc7
`define CCA_MODE_RESET    8'h00

// module_mode_reg fields
`define CCA_MM_IRQ_EN     0
`define CCA_MM_PULSE      1
`define CCA_MM_TOGGLE     2
`define CCA_MM_MATCH      3
`define CCA_MM_FALL       4
`define CCA_MM_RISE       5
`define CCA_MM_COMP       6
`define CCA_MM_MASK       8'h7f
`define CCA_MM_RESET      8'h00

// Count source select codes
`define CCA_SRC_SLOW      2'h0
`define CCA_SRC_FAST      2'h1
`define CCA_SRC_TIMER0    2'h2
`define CCA_SRC_EXT       2'h3

// Prescaler terminal counts (divide ratio minus one)
`define CCA_DIV_SLOW_6    4'h5
`define CCA_DIV_SLOW_12   4'hb
`define CCA_DIV_FAST_6    4'h1
`define CCA_DIV_FAST_12   4'h3

`define CCA_BYTE_MAX      8'hff
`define CCA_COUNT_MAX     16'hffff
`define CCA_PIN_RESET     1'b1

`endif

// ---- design/cca_counter_array.v ----
/*
  Counter array: one shared 16-bit timer with five capture/compare
  modules, reached over APB. Modules do edge capture, software timer,
  high-speed toggle output, 8-bit pulse output, and module 4 can act as
  a watchdog that raises an internal reset pulse.
  Assumes clk is the device oscillator, idleMode and timer0Overflow come
  from logic on clk, and pins arrive asynchronously.
*/
// Function
// - Two select bits choose counter tick source
// - Idle-halt bit stops counter in idle
// - Watchdog on module 4 only when enabled
// - Run bit starts and stops counter
// - Overflow sets flag; only software clears
// - Per-module event flags, software-cleared only
// - Module interrupt needs flag and enable
// - Toggle bit inverts pin on match; code also needs the match-flag bit set
// - Match-flag bit sets flag on match
// - Fall/rise bits arm capture edges
// - Comparator works only when enabled
// - Pulse bit plus comparator gives pulse mode
// - Armed edge captures counter, sets flag
// - Comparator plus match gives software timer
// - Toggle, match, comparator give fast output
// - Pulse low below compare, else high
// - Low compare reloads from high on wrap
// - Pulse outputs share frequency, own duty
// - Module pins and count input mapping
// - Five modules share one 16-bit counter
// - Watchdog match gives internal reset only
`timescale 1ns/1ns
`default_nettype none
`include "cca_defines.vh"

module cca_counter_array (
  // System
  input  wire        clk,
  input  wire        rst,
  input  wire        clkEn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Core side
  input  wire        sixClockMode,
  input  wire        idleMode,
  input  wire        timer0Overflow,
  output wire        irq,
  output reg         guardReset,
  // Port pins
  input  wire        extCountIn,
  input  wire [4:0]  modulePinIn,
  output wire [4:0]  modulePinOut,
  output wire [4:0]  modulePinOeN
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [5:0]  syncA;
  reg  [5:0]  syncB;
  reg  [5:0]  syncC;
  reg  [5:0]  pinStable;
  reg  [5:0]  pinPrev;
  reg  [3:0]  preCnt;
  reg  [15:0] count;
  reg         stepDone;
  reg  [7:0]  ctrlReg;
  reg  [7:0]  modeReg;
  wire [5:0]  pinRise;
  wire [5:0]  pinFall;
  wire [3:0]  preTop;
  wire [1:0]  srcSel;
  wire        preTick;
  reg         srcTick;
  wire        step;
  wire        overflow;
  wire        lowWrap;
  wire        setupPhase;
  wire        wrEn;
  wire [6:0]  page;
  wire [2:0]  modIdx;
  wire        modIdxOk;
  wire [4:0]  eventSet;
  wire [4:0]  matchVec;
  wire [4:0]  modIrq;
  wire [39:0] modeVec;
  wire [39:0] loVec;
  wire [39:0] hiVec;
  reg  [31:0] next_prdata;
  reg         next_pslverr;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA     <= 6'h00;
      syncB     <= 6'h00;
      syncC     <= 6'h00;
      pinStable <= 6'h00;
      pinPrev   <= 6'h00;
    end
    else if (clkEn)
    begin
      syncA     <= {extCountIn, modulePinIn};
      syncB     <= syncA;
      syncC     <= syncB;
      pinStable <= (~(syncB ^ syncC) & syncC) | ((syncB ^ syncC) & pinStable);
      pinPrev   <= pinStable;
    end
  end

  assign pinRise = pinStable & ~pinPrev;
  assign pinFall = ~pinStable & pinPrev;

  ////////////////////////////////////////////////////////////////////
  // Count source and prescaler

  assign srcSel = {modeReg[`CCA_MODE_SEL_HI], modeReg[`CCA_MODE_SEL_LO]};
  assign preTop = (srcSel == `CCA_SRC_SLOW)
                  ? (sixClockMode ? `CCA_DIV_SLOW_6 : `CCA_DIV_SLOW_12)
                  : (sixClockMode ? `CCA_DIV_FAST_6 : `CCA_DIV_FAST_12);
  assign preTick = (preCnt == preTop);

  always @*
  begin
    if (srcSel == `CCA_SRC_TIMER0)
      srcTick = timer0Overflow;
    else if (srcSel == `CCA_SRC_EXT)
      srcTick = pinRise[5];
    else
      srcTick = preTick;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      preCnt <= 4'h0;
    else if (clkEn)
    begin
      if (preTick || preCnt > preTop)
        preCnt <= 4'h0;
      else
        preCnt <= preCnt + 4'h1;
    end
  end

  // Idle halt only applies while the core reports idle
  assign step = clkEn && ctrlReg[`CCA_CTRL_RUN] && srcTick
                && !(idleMode && modeReg[`CCA_MODE_IDLE]);
  assign overflow = step && (count == `CCA_COUNT_MAX);
  assign lowWrap  = step && (count[7:0] == `CCA_BYTE_MAX);

  ////////////////////////////////////////////////////////////////////
  // APB decode

  assign pready     = clkEn;
  assign setupPhase = clkEn && psel && !penable;
  assign wrEn       = clkEn && psel && penable && pwrite;
  assign page       = paddr[11:5];
  assign modIdx     = paddr[4:2];
  assign modIdxOk   = (modIdx < `CCA_NUM_MOD) && (paddr[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////
  // Shared counter

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count    <= 16'h0000;
      stepDone <= 1'b0;
    end
    else if (clkEn)
    begin
      // A tick lost to a software counter write must not look like a match
      stepDone <= step && !(wrEn && (paddr == `CCA_OFF_TLOW || paddr == `CCA_OFF_THIGH));
      // Software writes to the counter win over a tick in the same cycle
      if (wrEn && paddr == `CCA_OFF_TLOW)
        count[7:0] <= pwdata[7:0];
      else if (wrEn && paddr == `CCA_OFF_THIGH)
        count[15:8] <= pwdata[7:0];
      else if (step)
        count <= count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and mode registers

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrlReg <= `CCA_CTRL_RESET;
      modeReg <= `CCA_MODE_RESET;
    end
    else if (clkEn)
    begin
      // Hardware sets win over a software clear in the same cycle
      if (wrEn && paddr == `CCA_OFF_CTRL)
        ctrlReg <= (pwdata[7:0] & `CCA_CTRL_MASK) | {overflow, 2'h0, eventSet};
      else
        ctrlReg <= ctrlReg | {overflow, 2'h0, eventSet};
      if (wrEn && paddr == `CCA_OFF_MODE)
        modeReg <= pwdata[7:0] & `CCA_MODE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Capture/compare modules

  genvar gi;
  generate
    for (gi = 0; gi < `CCA_NUM_MOD; gi = gi + 1)
    begin : modSlot
      reg  [7:0] mMode;
      reg  [7:0] mLo;
      reg  [7:0] mHi;
      reg        pinOut;
      wire       pulse;
      wire       capture;
      wire       wrMode;
      wire       wrLo;
      wire       wrHi;

      assign wrMode = wrEn && modIdxOk && page == `CCA_PAGE_MODMODE && modIdx == gi;
      assign wrLo   = wrEn && modIdxOk && page == `CCA_PAGE_MODLO && modIdx == gi;
      assign wrHi   = wrEn && modIdxOk && page == `CCA_PAGE_MODHI && modIdx == gi;
      assign pulse  = mMode[`CCA_MM_PULSE] && mMode[`CCA_MM_COMP];
      // Equality is judged on the cycle after each count step
      assign matchVec[gi] = mMode[`CCA_MM_COMP] && stepDone
                            && (count == {mHi, mLo});
      assign capture = !pulse && ((mMode[`CCA_MM_FALL] && pinFall[gi])
                       || (mMode[`CCA_MM_RISE] && pinRise[gi]));
      assign eventSet[gi] = capture
                            || (!pulse && matchVec[gi] && mMode[`CCA_MM_MATCH]);
      assign modIrq[gi] = ctrlReg[gi] && mMode[`CCA_MM_IRQ_EN];
      assign modeVec[gi*8 +: 8] = mMode;
      assign loVec[gi*8 +: 8]   = mLo;
      assign hiVec[gi*8 +: 8]   = mHi;
      assign modulePinOut[gi]   = pinOut;
      // Pin is driven only in pulse or toggle output use
      assign modulePinOeN[gi]   = !(pulse || (mMode[`CCA_MM_TOGGLE] && mMode[`CCA_MM_COMP]));

      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          mMode  <= `CCA_MM_RESET;
          mLo    <= 8'h00;
          mHi    <= 8'h00;
          pinOut <= `CCA_PIN_RESET;
        end
        else if (clkEn)
        begin
          if (wrMode)
            mMode <= pwdata[7:0] & `CCA_MM_MASK;
          if (capture)
          begin
            mLo <= count[7:0];
            mHi <= count[15:8];
          end
          else
          begin
            if (wrHi)
              mHi <= pwdata[7:0];
            if (pulse && lowWrap)
              mLo <= mHi;
            else if (wrLo)
              mLo <= pwdata[7:0];
          end
          if (pulse)
            pinOut <= (count[7:0] >= mLo);
          else if (matchVec[gi] && mMode[`CCA_MM_TOGGLE] && mMode[`CCA_MM_MATCH])
            pinOut <= ~pinOut;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Watchdog and interrupt request

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      guardReset <= 1'b0;
    else if (clkEn)
      guardReset <= modeReg[`CCA_MODE_GUARD] && matchVec[`CCA_GUARD_MOD];
  end

  assign irq = (ctrlReg[`CCA_CTRL_OVF] && modeReg[`CCA_MODE_OVF_IE]) || (|modIrq);

  ////////////////////////////////////////////////////////////////////
  // APB read data, sampled in the setup cycle

  always @*
  begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (paddr == `CCA_OFF_CTRL)
      next_prdata[7:0] = ctrlReg;
    else if (paddr == `CCA_OFF_MODE)
      next_prdata[7:0] = modeReg;
    else if (paddr == `CCA_OFF_TLOW)
      next_prdata[7:0] = count[7:0];
    else if (paddr == `CCA_OFF_THIGH)
      next_prdata[7:0] = count[15:8];
    else if (modIdxOk && page == `CCA_PAGE_MODMODE)
      next_prdata[7:0] = modeVec[{modIdx, 3'h0} +: 8];
    else if (modIdxOk && page == `CCA_PAGE_MODLO)
      next_prdata[7:0] = loVec[{modIdx, 3'h0} +: 8];
    else if (modIdxOk && page == `CCA_PAGE_MODHI)
      next_prdata[7:0] = hiVec[{modIdx, 3'h0} +: 8];
    else
      next_pslverr = 1'b1;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule // cca_counter_array

`default_nettype wire

// ---- bench/cca_monitor.sv ----
/*
  Port checker for the counter array.
  Assumes a bind onto cca_counter_array.
*/
`timescale 1ns/1ns
`default_nettype none
module cca_monitor (
  // Clock, reset, APB
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Core and pins
  input wire logic        guardReset,
  input wire logic [4:0]  modulePinOut,
  input wire logic [4:0]  modulePinOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_rd;
    psel && !penable && clkEn && !pwrite;
  endsequence
  sequence s_bad;
    s_rd ##0 paddr == 12'h034;
  endsequence
  a_read_holds: assert property (!(psel && !penable && clkEn) |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved outside setup");
  a_bad_addr: assert property (s_bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped taken");
  a_ctrl_spare: assert property (s_rd ##0 paddr == 12'h000 |=> !prdata[5])
    else $error("ctrl spare set");
  a_mode_top: assert property (s_rd ##0 paddr[11:4] == 8'h02 |=> !prdata[7])
    else $error("mode top set");
  a_rd_high: assert property (s_rd |=> prdata[31:8] == 24'h0)
    else $error("high bits set");
  a_guard_pulse: assert property (guardReset |=> !guardReset)
    else $error("guard pulse long");
  a_pins_held: assert property (modulePinOeN == 5'h1f && $past(modulePinOeN) == 5'h1f
    |-> $stable(modulePinOut)) else $error("pin moved");
  a_state_frozen: assert property (!clkEn |=> $stable(modulePinOut) && $stable(prdata))
    else $error("moved while frozen");
endmodule // cca_monitor
bind cca_counter_array cca_monitor i_mon (.clk(clk), .rst(rst), .clkEn(clkEn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .guardReset(guardReset),
  .modulePinOut(modulePinOut), .modulePinOeN(modulePinOeN));
`default_nettype wire

// ---- bench/cca_core_model.sv ----
/*
  Core-side model: timer 0 overflow pulses and count pin.
  Assumes the block's clock and reset.
*/
`timescale 1ns/1ns
`default_nettype none
module cca_core_model (
  // System
  input  wire logic clk,
  input  wire logic rst,
  // Core side
  input  wire logic idleReq,
  output var  logic timer0Overflow,
  output var  logic idleMode,
  output var  logic extCountIn
);
  logic [2:0] div;
  assign idleMode = idleReq;
  always @(posedge clk or posedge rst)
    if (rst)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  assign timer0Overflow = (div == 3'h7);
  assign extCountIn = div[2];
endmodule // cca_core_model
`default_nettype wire

// ---- bench/cca_counter_array_tb.sv ----
/*
  Self-checking bench for the counter array.
  Assumes checker and core model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module cca_counter_array_tb;
  logic        clk = 1'b0, rst = 1'b1, clkEn = 1'b1;
  logic        sixClk = 1'b0, idleReq = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, irq, guardReset, t0Ovf, idle, ext_count_in;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h5b5ec795;
  logic [4:0]  pinIn = 5'h00, pinOut, pinOeN;
  logic [32:0] expQ[$];
  int          fail_count = 0, comparisons = 0, pulses = 0, pulseBase = 0;
  always #10 clk = ~clk;
  cca_counter_array i_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sixClockMode(sixClk),
    .idleMode(idle), .timer0Overflow(t0Ovf), .irq(irq), .guardReset(guardReset),
    .extCountIn(ext_count_in), .modulePinIn(pinIn), .modulePinOut(pinOut), .modulePinOeN(pinOeN));
  cca_core_model i_core (.clk(clk), .rst(rst), .idleReq(idleReq), .timer0Overflow(t0Ovf),
    .idleMode(idle), .extCountIn(ext_count_in));
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic fail(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp)
      fail(m);
  endtask
  task automatic cmp_read(input logic [32:0] e);
    comparisons++;
    if ({pslverr, prdata} !== e)
      fail("read data");
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wr16(input logic [11:0] a, input logic [11:0] step, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + step, v[15:8]);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
    expQ.push_back({err, 24'h0, e});
    apb(1'b0, a, 8'h00);
  endtask
  // 120 counting edges hold a whole number of tick periods whatever the prescaler phase
  task automatic run_count(input logic [7:0] md, input logic six, input logic idl,
                           input logic [7:0] e);
    sixClk <= six;
    idleReq <= idl;
    wr(12'h004, md);
    wr16(12'h008, 12'h004, 16'h0000);
    wr(12'h000, 8'h40);
    repeat (117) @(posedge clk);
    wr(12'h000, 8'h00);
    rd(12'h008, e);
  endtask
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      if (expQ.size() == 0)
        fail("stray read");
      else
        cmp_read(expQ.pop_front());
  always @(posedge clk)
    if (guardReset === 1'b1)
      pulses <= pulses + 1;
  ////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int n = 0; n < 5; n++)
      rd(12'h020 + 12'(4 * n), 8'h00);
    rd(12'h000, 8'h00);
    rd(12'h004, 8'h00);
    rd(12'h034, 8'h00, 1'b1);
    cmp_val({3'h0, pinOut}, 8'h1f, "pin reset");
    lfsr = lfsr_step(lfsr);
    wr16(12'h008, 12'h004, lfsr[15:0]);
    clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    rd(12'h008, lfsr[7:0]);
    rd(12'h00c, lfsr[15:8]);
    // Software timer, module 0
    wr16(12'h040, 12'h020, 16'h0005);
    wr(12'h020, 8'h48);
    wr(12'h004, 8'h02);
    wr16(12'h008, 12'h004, 16'h0000);
    wr(12'h000, 8'h40);
    repeat (40) @(posedge clk);
    rd(12'h000, 8'h41);
    cmp_val({7'h0, irq}, 8'h00, "irq masked");
    wr(12'h020, 8'h49);
    cmp_val({7'h0, irq}, 8'h01, "irq set");
    wr(12'h000, 8'h00);
    cmp_val({7'h0, irq}, 8'h00, "irq clear");
    // Toggle output, module 1
    wr16(12'h044, 12'h020, 16'h0010);
    wr(12'h024, 8'h4c);
    wr16(12'h008, 12'h004, 16'h0000);
    cmp_val({7'h0, pinOeN[1]}, 8'h00, "toggle drive");
    wr(12'h000, 8'h40);
    repeat (100) @(posedge clk);
    cmp_val({7'h0, pinOut[1]}, 8'h00, "toggle");
    rd(12'h000, 8'h43);
    wr(12'h000, 8'h00);
    // Capture: module 2 on rise, module 3 on fall only
    lfsr = lfsr_step(lfsr);
    wr16(12'h008, 12'h004, lfsr[15:0]);
    wr(12'h028, 8'h20);
    wr(12'h02c, 8'h10);
    pinIn <= 5'h0c;
    repeat (10) @(posedge clk);
    rd(12'h048, lfsr[7:0]);
    rd(12'h068, lfsr[15:8]);
    rd(12'h000, 8'h04);
    pinIn <= 5'h00;
    repeat (10) @(posedge clk);
    rd(12'h000, 8'h0c);
    // Pulse output, module 0
    wr(12'h020, 8'h42);
    wr16(12'h040, 12'h020, 16'h8000);
    wr16(12'h008, 12'h004, 16'h00f0);
    wr(12'h000, 8'h40);
    repeat (20) @(posedge clk);
    cmp_val({7'h0, pinOut[0]}, 8'h01, "pulse high");
    cmp_val({7'h0, pinOeN[0]}, 8'h00, "pulse drive");
    repeat (80) @(posedge clk);
    cmp_val({7'h0, pinOut[0]}, 8'h00, "pulse low");
    rd(12'h040, 8'h80);
    wr(12'h000, 8'h00);
    // Guard on module 4, then off with overflow
    wr(12'h030, 8'h48);
    wr16(12'h050, 12'h020, 16'h0004);
    wr16(12'h008, 12'h004, 16'h0000);
    wr(12'h004, 8'h42);
    pulseBase = pulses;
    wr(12'h000, 8'h40);
    repeat (50) @(posedge clk);
    cmp_val(8'(pulses - pulseBase), 8'h01, "guard on");
    wr(12'h000, 8'h00);
    wr16(12'h008, 12'h004, 16'hfffc);
    wr(12'h004, 8'h03);
    pulseBase = pulses;
    wr(12'h000, 8'h40);
    repeat (50) @(posedge clk);
    cmp_val(8'(pulses - pulseBase), 8'h00, "guard off");
    rd(12'h000, 8'hd0);
    cmp_val({7'h0, irq}, 8'h01, "ovf irq");
    // Every count source and clock mode, then idle with and without halt
    run_count(8'h00, 1'b0, 1'b0, 8'h0a);
    run_count(8'h00, 1'b1, 1'b0, 8'h14);
    run_count(8'h02, 1'b1, 1'b0, 8'h3c);
    run_count(8'h02, 1'b0, 1'b0, 8'h1e);
    run_count(8'h04, 1'b0, 1'b0, 8'h0f);
    run_count(8'h06, 1'b0, 1'b0, 8'h0f);
    run_count(8'h82, 1'b0, 1'b1, 8'h00);
    run_count(8'h02, 1'b0, 1'b1, 8'h1e);
    finish_test;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail("timeout");
    finish_test;
  end
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // cca_counter_array_tb
`default_nettype wire
